// File: rtl/lsga_bit_if.sv
// Bit-level signals between the receive path and the clock recovery
`timescale 1ns/1ns
`default_nettype none
interface lsga_bit_if;
    logic line_in;
    logic bit_stb;
    logic bit_val;
    logic rclk;
    modport cdr  (input line_in, output bit_stb, output bit_val, output rclk);
    modport user (output line_in, input bit_stb, input bit_val, input rclk);
endinterface
`default_nettype wire

// File: rtl/lsga_cdr.sv
// Recovers bit timing and a recovered clock from the oversampled line
`timescale 1ns/1ns
`default_nettype none
module lsga_cdr
    import lsga_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    lsga_bit_if.cdr    bit_if
);
    logic [OVS_W-1:0] ph_q;
    logic             prev_q;
    logic             stb_q;
    logic             val_q;
    logic             rclk_q;

    // ------------------------------------------------------------
    // Phase tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ph_q   <= '0;
            prev_q <= 1'b0;
        end else begin
            prev_q <= bit_if.line_in;
            if (bit_if.line_in != prev_q) begin
                ph_q <= '0;
            end else if (ph_q == OVS_LAST) begin
                ph_q <= '0;
            end else begin
                ph_q <= ph_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit sample and recovered clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stb_q  <= 1'b0;
            val_q  <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            stb_q  <= (ph_q == SAMPLE_PH) && (bit_if.line_in == prev_q);
            val_q  <= bit_if.line_in;
            rclk_q <= (ph_q < RCLK_HI);
        end
    end

    assign bit_if.bit_stb = stb_q;
    assign bit_if.bit_val = val_q;
    assign bit_if.rclk    = rclk_q;
endmodule
`default_nettype wire

// File: rtl/lsga_pkg.sv
// Constants shared by the line serialiser, gap adapter and clock recovery
package lsga_pkg;
    localparam int          CG_W      = 10;           // Code group width
    localparam int          OVS_W     = 2;            // Oversample counter width
    localparam logic [1:0]  OVS_LAST  = 2'h3;         // Four clocks per line bit
    localparam logic [1:0]  SAMPLE_PH = 2'h2;         // Mid-bit sample phase
    localparam logic [1:0]  RCLK_HI   = 2'h2;         // Recovered clock high below this phase
    localparam int          COMMA_W   = 7;
    localparam logic [6:0]  COMMA_CG  = 7'h1f;        // 1111100 in line order, first bit in bit 0
    localparam logic [3:0]  BIT_LAST  = 4'h9;
    localparam logic [3:0]  BIT_AFTER_COMMA = 4'h7;
    localparam logic [3:0]  BIT_ZERO  = 4'h0;
    localparam logic [9:0]  GAP_CG    = 10'h29f;      // Gap code group, starts with a comma
    localparam logic [9:0]  CG_ZERO   = 10'h000;
    typedef logic [CG_W-1:0] lsga_cg_t;
endpackage

// File: rtl/lsga_top.sv
// Line serialiser, deserialiser, comma aligner and gap adapter
// Function
// - Converts 10-bit code groups to a 1-bit line stream and back.
// - Every bit of each accepted code group goes onto the serial line.
// - Receive splits the line into code groups; boundary fixed only while enabled.
// - A recovered clock is regenerated from the received line transitions.
// - Transmit inserts gap code groups when no payload is waiting.
// - Receive removes gap code groups before passing data on.
// - Gap insertion and removal never reorder payload words; a payload word equal to GAP_CG is dropped.
// - Frame start pulses only on a comma seen while alignment is enabled.
`timescale 1ns/1ns
`default_nettype none
module lsga_top
    import lsga_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire lsga_pkg::lsga_cg_t tx_codegroup_i,
    input  wire logic             tx_valid_i,
    output var  logic             tx_ready_o,
    output var  logic             line_serial_bitstream_o,
    input  wire logic             line_serial_bitstream_i,
    input  wire logic             align_enable_i,
    output var  lsga_pkg::lsga_cg_t rx_codegroup_o,
    output var  logic             rx_valid_o,
    output var  logic             frame_start_flag_o,
    output var  logic             recovered_clock_o
);
    import lsga_pkg::*;

    // ------------------------------------------------------------
    // Transmit holding word and serialiser
    // ------------------------------------------------------------
    lsga_cg_t         hold_q;
    logic             full_q;
    lsga_cg_t         sh_q;
    logic [3:0]       tx_bit_q;
    logic [OVS_W-1:0] tx_ph_q;
    logic             tx_bit_end;
    logic             tx_load;
    logic             tx_take;
    logic             full_d;

    assign tx_bit_end = (tx_ph_q == OVS_LAST);
    assign tx_load    = tx_bit_end && (tx_bit_q == BIT_LAST);
    assign tx_take    = tx_valid_i && tx_ready_o;
    assign full_d     = tx_take || (full_q && !tx_load);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hold_q     <= CG_ZERO;
            full_q     <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            if (tx_take) begin
                hold_q <= tx_codegroup_i;
            end
            full_q     <= full_d;
            tx_ready_o <= !full_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sh_q     <= GAP_CG;
            tx_bit_q <= BIT_ZERO;
            tx_ph_q  <= '0;
            line_serial_bitstream_o <= 1'b0;
        end else begin
            tx_ph_q <= tx_bit_end ? '0 : tx_ph_q + 1'b1;
            if (tx_load) begin
                sh_q     <= full_q ? hold_q : GAP_CG;
                tx_bit_q <= BIT_ZERO;
            end else if (tx_bit_end) begin
                sh_q     <= {1'b0, sh_q[CG_W-1:1]};
                tx_bit_q <= tx_bit_q + 1'b1;
            end
            line_serial_bitstream_o <= sh_q[0];
        end
    end

    // ------------------------------------------------------------
    // Clock recovery
    // ------------------------------------------------------------
    lsga_bit_if bit_if ();
    assign bit_if.line_in = line_serial_bitstream_i;

    lsga_cdr u_cdr (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .bit_if   (bit_if)
    );

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            recovered_clock_o <= 1'b0;
        end else begin
            recovered_clock_o <= bit_if.rclk;
        end
    end

    // ------------------------------------------------------------
    // Deserialiser and comma aligner
    // ------------------------------------------------------------
    lsga_cg_t   win_q;
    lsga_cg_t   win_d;
    logic [3:0] rx_bit_q;
    logic       comma_hit;

    assign win_d     = {bit_if.bit_val, win_q[CG_W-1:1]};
    assign comma_hit = (win_d[CG_W-1:CG_W-COMMA_W] == COMMA_CG);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            win_q    <= CG_ZERO;
            rx_bit_q <= BIT_ZERO;
        end else if (bit_if.bit_stb) begin
            win_q <= win_d;
            if (comma_hit && align_enable_i) begin
                rx_bit_q <= BIT_AFTER_COMMA;
            end else if (rx_bit_q == BIT_LAST) begin
                rx_bit_q <= BIT_ZERO;
            end else begin
                rx_bit_q <= rx_bit_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            frame_start_flag_o <= 1'b0;
        end else begin
            frame_start_flag_o <= bit_if.bit_stb && comma_hit && align_enable_i;
        end
    end

    // ------------------------------------------------------------
    // Gap removal
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_codegroup_o <= CG_ZERO;
            rx_valid_o     <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (bit_if.bit_stb && (rx_bit_q == BIT_LAST)
                && !(comma_hit && align_enable_i)) begin
                rx_codegroup_o <= win_d;
                rx_valid_o     <= (win_d != GAP_CG);
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/lsga_line_model.sv
// Optical line stage model that loops the transmit line back
`timescale 1ns/1ns
`default_nettype none
module lsga_line_model (
    input  wire logic clk_i,
    input  wire logic line_i,
    output var  logic line_o
);
    // One clock of line delay
    always_ff @(posedge clk_i) begin
        line_o <= line_i;
    end
endmodule
`default_nettype wire

// File: tb/lsga_top_properties.sv
// Port checker for the line serialiser and gap adapter
`timescale 1ns/1ns
`default_nettype none
module lsga_top_properties
    import lsga_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               resetn_i,
    input wire logic               tx_valid_i,
    input wire logic               tx_ready_o,
    input wire logic               line_serial_bitstream_o,
    input wire logic               align_enable_i,
    input wire lsga_pkg::lsga_cg_t rx_codegroup_o,
    input wire logic               rx_valid_o,
    input wire logic               frame_start_flag_o,
    input wire logic               recovered_clock_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rst;
        disable iff (1'b0) !resetn_i |=> !tx_ready_o && !rx_valid_o && !frame_start_flag_o;
    endproperty
    property p_take; tx_valid_i && tx_ready_o |=> !tx_ready_o; endproperty
    property p_hold; $changed(line_serial_bitstream_o) |=> $stable(line_serial_bitstream_o) [*3]; endproperty
    property p_rclk; $rose(recovered_clock_o) |=> recovered_clock_o ##1 !recovered_clock_o; endproperty
    property p_fs_en; frame_start_flag_o |-> $past(align_enable_i) || $past(align_enable_i, 2); endproperty
    property p_fs_pulse; frame_start_flag_o |=> !frame_start_flag_o [*8]; endproperty
    property p_rx_pulse; rx_valid_o |=> !rx_valid_o [*8]; endproperty
    property p_no_gap; rx_valid_o |-> rx_codegroup_o != GAP_CG; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_take: assert property (p_take) else $error("ready held after a take");
    a_hold: assert property (p_hold) else $error("line bit shorter than four clocks");
    a_rclk: assert property (p_rclk) else $error("recovered clock high time wrong");
    a_fs_en: assert property (p_fs_en) else $error("frame start without enable");
    a_fs_pulse: assert property (p_fs_pulse) else $error("frame start too long");
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive words too close");
    a_no_gap: assert property (p_no_gap) else $error("gap word passed on");
    c_take: cover property (tx_valid_i && tx_ready_o);
    c_fs: cover property (frame_start_flag_o);
    c_rx: cover property (rx_valid_o);
endmodule
bind lsga_top lsga_top_properties lsga_top_properties_inst (.clk_i, .resetn_i, .tx_valid_i, .tx_ready_o,
    .line_serial_bitstream_o, .align_enable_i, .rx_codegroup_o, .rx_valid_o, .frame_start_flag_o,
    .recovered_clock_o);
`default_nettype wire

// File: tb/test_line_serdes_gap_adapt.sv
// Loopback testbench for the line serialiser and gap adapter
`timescale 1ns/1ns
`default_nettype none
module test_line_serdes_gap_adapt;
    import lsga_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tx_valid_i = 1'b0;
    logic align_enable_i = 1'b0;
    lsga_cg_t tx_codegroup_i = CG_ZERO;
    lsga_cg_t rx_codegroup_o;
    logic tx_ready_o, line_tx, line_rx, rx_valid_o, frame_start_flag_o, recovered_clock_o;
    int err_total = 0;
    int n_compared = 0;
    int fs_cnt = 0;
    int rc_cnt = 0;
    logic rc_prev = 1'b0;
    lsga_cg_t got_q[$];
    logic [19:0] rows [4] = '{{10'h155, 10'h155}, {10'h2aa, 10'h2aa}, {10'h3ff, 10'h3ff}, {10'h29e, 10'h29e}};
    always #25 clk_i = ~clk_i;
    lsga_top lsga_top_inst (.clk_i, .resetn_i, .tx_codegroup_i, .tx_valid_i, .tx_ready_o,
        .line_serial_bitstream_o(line_tx), .line_serial_bitstream_i(line_rx), .align_enable_i,
        .rx_codegroup_o, .rx_valid_o, .frame_start_flag_o, .recovered_clock_o);
    lsga_line_model lsga_line_model_inst (.clk_i, .line_i(line_tx), .line_o(line_rx));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(input lsga_cg_t cg);
        @(negedge clk_i);
        tx_codegroup_i = cg;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Collects received words and frame starts
    always @(negedge clk_i) begin
        if (rx_valid_o === 1'b1) got_q.push_back(rx_codegroup_o);
        if (frame_start_flag_o === 1'b1) fs_cnt++;
        if (recovered_clock_o === 1'b1 && rc_prev === 1'b0) rc_cnt++;
        rc_prev <= recovered_clock_o;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        chk({7'h00, tx_ready_o, rx_valid_o, frame_start_flag_o}, 10'h000);
        resetn_i = 1'b1;
        align_enable_i = 1'b1;
        $display("reset test done");
        repeat (200) if (fs_cnt == 0) @(negedge clk_i);
        chk(10'(fs_cnt != 0), 10'h001);
        align_enable_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rc_cnt = 0;
        repeat (40) @(negedge clk_i);
        chk(10'(rc_cnt), 10'h00a);
        fs_cnt = 0;
        got_q.delete();
        $display("align test done");
        foreach (rows[i]) send(rows[i][19:10]);
        send(GAP_CG);
        send(10'h0f0);
        repeat (200) @(negedge clk_i);
        chk(10'(got_q.size()), 10'h005);
        foreach (rows[i]) chk(got_q[i], rows[i][9:0]);
        chk(got_q[4], 10'h0f0);
        chk(10'(fs_cnt), 10'h000);
        $display("data test done");
        end_of_test();
    end
endmodule
`default_nettype wire
